// *** acp_port.sv ***
// Behaviour
// [R1] In DSP mode a frame-sync pulse starts a new conversion.
// [R2] Host holds frame-sync input high when not using DSP mode.
// [R3] Width select low gives 8-bit transfers, high gives 16-bit.
// [R4] Host always drives width select to a defined level.
// [R5] In DSP mode a frame-sync output pulse marks MSB on data out.
// [R6] External reference: chip select high shuts down, low runs.
// [R7] Chip select falling wakes analog and enables command shifting.
// [R8] Host serial clock edges pace acquisition and conversion.
// [R9] Data out low until ready; MSB at 8th or 16th falling edge.
// [R10] Result shifted out unsigned binary, MSB first.
// [R11] In DSP mode serial clock drives conversion after frame sync.
// [R12] Track/hold opens at end of acquisition, holding the sample.
// [R13] Host toggles chip select after each conversion to retrack.
// [R14] 16-bit mode acquisition lasts 11.5 serial clock cycles.
// [R15] Host keeps acquisition at least 729 ns.
// [R16] Data out shifts on fall (SPI) or rise (DSP); off when deselected.
// [R17] Data in sampled on rising (SPI) or falling (DSP) edges.
// [R18] End-of-conversion low when result ready in internal clock mode.
`timescale 1ns/1ps
`default_nettype none
module acp_port
   import acp_pkg::*;
(
   input  wire logic                    clk_i,
   input  wire logic                    reset_i,
   input  wire logic                    cs_n_i,
   input  wire logic                    sclk_i,
   input  wire logic                    din_i,
   input  wire logic                    frame_sync_in_i,
   input  wire logic                    transfer_width_select_i,
   input  wire logic                    internal_clock_i,
   input  wire logic [1:0]              pd_select_i,
   input  wire logic [ACP_RES_BITS-1:0] sample_code_i,
   output logic                         dout_o,
   output logic                         dout_oe_o,
   output logic                         frame_sync_out_o,
   output logic                         eoc_n_o,
   output logic                         shutdown_o,
   output logic                         analog_awake_o,
   output logic                         track_o,
   output logic [ACP_CMD_BITS-1:0]      command_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   // Idle-high pins pass inverted so the synchroniser's reset value is
   // their idle level; otherwise a false select and sync edge follow reset
   logic [4:0] pins_s;
   acp_sync #(.W(5)) u_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .d_i     ({~cs_n_i, sclk_i, din_i, ~frame_sync_in_i,
                 transfer_width_select_i}),
      .q_o     (pins_s)
   );
   logic cs_n_s, sclk_s, din_s, fs_s, wide_s;
   logic cs_act_s, fs_act_s;
   assign {cs_act_s, sclk_s, din_s, fs_act_s, wide_s} = pins_s;
   assign cs_n_s = ~cs_act_s;
   assign fs_s   = ~fs_act_s;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   acp_state_t                state, next_state;
   logic                      cs_q, sclk_q, fs_q;
   logic                      dsp_mode, next_dsp_mode;
   logic                      wide, next_wide;
   logic [ACP_CNT_BITS-1:0]   half, next_half;
   logic [ACP_CNT_BITS-1:0]   fall, next_fall;
   logic [ACP_CNT_BITS-1:0]   nbit, next_nbit;
   logic [ACP_RES_BITS-1:0]   shreg, next_shreg;
   logic [ACP_CMD_BITS-1:0]   cmd, next_cmd;
   logic                      dout, next_dout;
   logic                      fso, next_fso;
   logic                      trk, next_trk;
   logic                      eoc_n, next_eoc_n;

   logic cs_fall, cs_rise, sck_rise, sck_fall, fs_fall;
   logic shift_edge, samp_edge;
   logic [ACP_CNT_BITS-1:0] acq_end, msb_edge;

   assign cs_fall  = cs_q & ~cs_n_s;
   assign cs_rise  = ~cs_q & cs_n_s;
   assign sck_rise = ~sclk_q & sclk_s;
   assign sck_fall = sclk_q & ~sclk_s;
   assign fs_fall  = fs_q & ~fs_s;
   // Output edge and input sampling edge swap in DSP mode
   assign shift_edge = dsp_mode ? sck_rise : sck_fall; // R16
   assign samp_edge  = dsp_mode ? sck_fall : sck_rise; // R17
   assign acq_end  = wide ? ACP_CNT_BITS'(ACP_ACQ_HALF_16)
                          : ACP_CNT_BITS'(ACP_ACQ_HALF_8); // R14
   assign msb_edge = wide ? ACP_CNT_BITS'(ACP_W16)
                          : ACP_CNT_BITS'(ACP_W8); // R3 R9

   always_comb begin
      next_state    = state;
      next_dsp_mode = dsp_mode;
      next_wide     = wide;
      next_half     = half;
      next_fall     = fall;
      next_nbit     = nbit;
      next_shreg    = shreg;
      next_cmd      = cmd;
      next_dout     = dout;
      next_fso      = 1'b0;
      next_trk      = trk;
      next_eoc_n    = 1'b1; // R18
      if (cs_n_s) begin
         next_state = ACP_IDLE;
         next_trk   = 1'b1; // R13
         next_dout  = 1'b0;
      end else begin
         case (state)
            ACP_IDLE: begin
               // Chip select fall wakes for SPI; frame sync fall starts DSP
               if (cs_fall && fs_s) begin // R7
                  next_state    = ACP_ACQ;
                  next_dsp_mode = 1'b0;
               end else if (fs_fall) begin // R1 R11
                  next_state    = ACP_ACQ;
                  next_dsp_mode = 1'b1;
               end
               next_wide = wide_s; // R3
               next_half = '0;
               next_nbit = '0;
               next_fall = '0;
               next_dout = 1'b0;
               next_trk  = 1'b1;
            end
            ACP_ACQ, ACP_CONV: begin
               if (sck_rise || sck_fall) begin // R8
                  next_half = half + 1'b1;
               end
               if (state == ACP_ACQ && (sck_rise || sck_fall)
                   && half + 1'b1 == acq_end) begin
                  next_trk   = 1'b0; // R12
                  next_shreg = sample_code_i;
                  next_state = ACP_CONV;
               end
               if (shift_edge) begin
                  next_fall = fall + 1'b1;
                  if (fall + 1'b1 == msb_edge) begin
                     // MSB first, unsigned code straight from the array
                     next_dout  = shreg[ACP_RES_BITS-1]; // R9 R10
                     next_shreg = {shreg[ACP_RES_BITS-2:0], 1'b0};
                     next_fso   = dsp_mode; // R5
                     next_state = ACP_DONE;
                  end else begin
                     next_dout = 1'b0; // R9
                  end
               end
            end
            ACP_DONE: begin
               if (shift_edge) begin
                  next_dout  = shreg[ACP_RES_BITS-1]; // R10 R16
                  next_shreg = {shreg[ACP_RES_BITS-2:0], 1'b0};
               end
               // Result waits until chip select is cycled or a frame sync falls
               next_eoc_n = ~internal_clock_i; // R18
            end
            default: next_state = ACP_IDLE;
         endcase
         // Command takes the first eight sampling edges of a frame in
         // either mode, even once the result has begun to shift out
         if (state != ACP_IDLE && samp_edge
             && nbit != ACP_CNT_BITS'(ACP_CMD_BITS)) begin
            next_cmd  = {cmd[ACP_CMD_BITS-2:0], din_s}; // R7 R17
            next_nbit = nbit + 1'b1;
         end
         // Select fall already opened an SPI frame, so a sync fall must
         // override it and start a fresh DSP conversion
         if (fs_fall) begin // R1 R11
            next_state    = ACP_ACQ;
            next_dsp_mode = 1'b1;
            next_wide     = wide_s; // R3
            next_half     = '0;
            next_fall     = '0;
            next_nbit     = '0;
            next_dout     = 1'b0;
            next_trk      = 1'b1;
            next_fso      = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state    <= ACP_IDLE;
         cs_q     <= 1'b1;
         sclk_q   <= 1'b0;
         fs_q     <= 1'b1;
         dsp_mode <= 1'b0;
         wide     <= 1'b0;
         half     <= '0;
         fall     <= '0;
         nbit     <= '0;
         shreg    <= '0;
         cmd      <= '0;
         dout     <= 1'b0;
         fso      <= 1'b0;
         trk      <= 1'b1;
         eoc_n    <= 1'b1;
      end else begin
         state    <= next_state;
         cs_q     <= cs_n_s;
         sclk_q   <= sclk_s;
         fs_q     <= fs_s;
         dsp_mode <= next_dsp_mode;
         wide     <= next_wide;
         half     <= next_half;
         fall     <= next_fall;
         nbit     <= next_nbit;
         shreg    <= next_shreg;
         cmd      <= next_cmd;
         dout     <= next_dout;
         fso      <= next_fso;
         trk      <= next_trk;
         eoc_n    <= next_eoc_n;
      end
   end

   // ------------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         dout_o           <= 1'b0;
         dout_oe_o        <= 1'b0;
         frame_sync_out_o <= 1'b0;
         eoc_n_o          <= 1'b1;
         shutdown_o       <= 1'b1;
         analog_awake_o   <= 1'b0;
         track_o          <= 1'b1;
         command_o        <= '0;
      end else begin
         dout_o           <= dout;
         dout_oe_o        <= ~cs_n_s; // R16
         frame_sync_out_o <= fso;
         eoc_n_o          <= eoc_n;
         // Only the external reference mode shuts down on select alone
         shutdown_o       <= cs_n_s && pd_select_i == ACP_PD_EXT_REF; // R6
         analog_awake_o   <= ~cs_n_s; // R6 R7
         track_o          <= trk;
         command_o        <= cmd;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   chk_oe_follows_cs: assert property (cs_n_s |=> !dout_oe_o) // R16
      else $error("data out enabled while deselected");
   chk_fso_dsp_only: assert property (fso |-> dsp_mode) // R5
      else $error("frame sync out outside DSP mode");
   chk_eoc_ext_high: assert property ( // R18
      !internal_clock_i && !$past(internal_clock_i) |-> eoc_n_o)
      else $error("end of conversion low in external clock mode");
   chk_eoc_int_low: assert property ( // R18
      state == ACP_DONE && !cs_n_s && internal_clock_i |=> !eoc_n)
      else $error("end of conversion high with result ready");
   chk_hold_on_conv: assert property (state == ACP_CONV |-> !trk) // R12
      else $error("tracking during conversion");
   chk_msb_count: assert property ( // R9
      state == ACP_DONE && $past(state) != ACP_DONE |-> fall == msb_edge)
      else $error("MSB on wrong edge");
   chk_wide_acq: assert property ( // R14
      state == ACP_CONV && $past(state) == ACP_ACQ |-> half == acq_end)
      else $error("acquisition length wrong");
   chk_dout_low: assert property (state == ACP_ACQ |-> !dout) // R9
      else $error("data out high before result");
   chk_cs_track: assert property (cs_n_s |=> trk) // R13
      else $error("no retrack after deselect");
   chk_fs_starts_dsp: assert property ( // R1
      fs_fall && !cs_n_s |=> state == ACP_ACQ && dsp_mode)
      else $error("frame sync did not start a conversion");
endmodule // acp_port
`default_nettype wire

// *** acp_pkg.sv ***
package acp_pkg;
   localparam int ACP_RES_BITS     = 16;
   localparam int ACP_CMD_BITS     = 8;
   localparam int ACP_W8           = 8;
   localparam int ACP_W16          = 16;
   // Acquisition end, counted in half serial-clock cycles
   localparam int ACP_ACQ_HALF_8   = 3;
   localparam int ACP_ACQ_HALF_16  = 23;
   localparam int ACP_CNT_BITS     = 7;
   localparam logic [1:0] ACP_PD_EXT_REF = 2'h3;
   typedef enum logic [1:0] {ACP_IDLE, ACP_ACQ, ACP_CONV, ACP_DONE} acp_state_t;
endpackage

// *** acp_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module acp_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta <= '0;
         q_o  <= '0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule // acp_sync
`default_nettype wire

// *** acp_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Host serial port model: sclk idles low and only runs in frames
// ----------------------------------------------------------------
module acp_host (
   input  wire logic clk_i,
   input  wire logic dout_i,
   output var  logic cs_n_o,
   output var  logic sclk_o,
   output var  logic din_o,
   output var  logic fs_o
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      din_o  = 1'b0;
      fs_o   = 1'b1;
   end
   // Four clocks a half gives the 64 ns serial period
   task automatic half(input logic lvl);
      @(posedge clk_i) sclk_o <= lvl;
      repeat (3) @(posedge clk_i);
   endtask
   task automatic take(input int e, input int first,
                       inout logic [15:0] res, inout logic pre);
      if (e >= 1 && e < first) pre = pre | dout_i;
      else if (e >= first && e < first + 16) res[15-(e-first)] = dout_i;
   endtask
   task automatic frame(input logic dsp, input int first,
                        input logic [7:0] cmd,
                        output logic [15:0] res, output logic pre);
      int k;
      res = 16'h0000;
      pre = 1'b0;
      @(posedge clk_i) cs_n_o <= 1'b0;
      // Long track time before the first edge covers the minimum
      repeat (96) @(posedge clk_i);
      if (dsp) begin
         @(posedge clk_i) fs_o <= 1'b0;
         repeat (7) @(posedge clk_i);
         @(posedge clk_i) fs_o <= 1'b1;
         repeat (7) @(posedge clk_i);
      end
      for (k = 1; k < first + 16; k++) begin
         din_o <= (k <= 8) ? cmd[8-k] : 1'b0;
         half(1'b1);
         if (!dsp) take(k - 1, first, res, pre);
         half(1'b0);
         if (dsp) take(k, first, res, pre);
      end
      if (!dsp) begin
         half(1'b1);
         take(first + 15, first, res, pre);
         half(1'b0);
      end
   endtask
   task automatic release_cs();
      @(posedge clk_i) cs_n_o <= 1'b1;
      repeat (8) @(posedge clk_i);
   endtask
endmodule // acp_host
`default_nettype wire

// *** acp_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
   begin check_count++; if ((got) !== (ex)) begin fail_count++; \
   $display("[ERR] %s exp %h got %h", nm, ex, got); end end
// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module acp_port_tb;
   import acp_pkg::*;
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        cs_n, sclk, din, fs, dout, dout_oe, fso, eoc_n;
   logic        shutdown, awake, track, wsel = 1'b0, intclk = 1'b0;
   logic [1:0]  pd = 2'h0;
   logic [15:0] code = 16'hb5a3;
   logic [7:0]  cmd;
   logic        dout_w;
   int          fail_count = 0, check_count = 0, fso_cnt = 0, cyc = 0;
   always #4 clk_i = ~clk_i;
   // Released line is pulled up, so a stale low never passes
   assign dout_w = dout_oe ? dout : 1'b1;
   acp_host host_u (.clk_i(clk_i), .dout_i(dout_w), .cs_n_o(cs_n),
      .sclk_o(sclk), .din_o(din), .fs_o(fs));
   acp_port dut_u (.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n),
      .sclk_i(sclk), .din_i(din), .frame_sync_in_i(fs),
      .transfer_width_select_i(wsel), .internal_clock_i(intclk),
      .pd_select_i(pd), .sample_code_i(code), .dout_o(dout),
      .dout_oe_o(dout_oe), .frame_sync_out_o(fso), .eoc_n_o(eoc_n),
      .shutdown_o(shutdown), .analog_awake_o(awake), .track_o(track),
      .command_o(cmd));
   always @(posedge clk_i) begin
      fso_cnt <= fso_cnt + (fso === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic final_report();
      if (fail_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic t_frame(input logic dsp, input logic w, input logic ic);
      logic [15:0] res;
      logic        pre;
      int          n0;
      @(posedge clk_i) wsel <= w;
      intclk <= ic;
      repeat (4) @(posedge clk_i);
      n0 = fso_cnt;
      host_u.frame(dsp, w ? ACP_W16 : ACP_W8, 8'ha6, res, pre);
      `CHK("result", code, res)
      `CHK("early_dout", 1'b0, pre)
      `CHK("fso_pulses", dsp ? 1 : 0, fso_cnt - n0)
      `CHK("track_hold", 1'b0, track)
      `CHK("awake", 1'b1, awake)
      `CHK("eoc_done", ~ic, eoc_n)
      `CHK("oe_sel", 1'b1, dout_oe)
      `CHK("command", 8'ha6, cmd)
      host_u.release_cs();
      `CHK("eoc_idle", 1'b1, eoc_n)
      `CHK("oe_desel", 1'b0, dout_oe)
      `CHK("retrack", 1'b1, track)
      code = ~code;
   endtask
   task automatic t_power();
      @(posedge clk_i) pd <= ACP_PD_EXT_REF;
      repeat (4) @(posedge clk_i);
      `CHK("shutdown", 1'b1, shutdown)
      `CHK("asleep", 1'b0, awake)
      @(posedge clk_i) pd <= 2'h0;
      repeat (4) @(posedge clk_i);
      `CHK("no_shutdown", 1'b0, shutdown)
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      t_power();
      t_frame(1'b0, 1'b0, 1'b0);
      t_frame(1'b0, 1'b1, 1'b1);
      t_frame(1'b1, 1'b0, 1'b0);
      t_frame(1'b1, 1'b1, 1'b0);
      final_report();
   end
endmodule // acp_port_tb
`default_nettype wire
